// file: src/rwc_clk_div.sv
// Purpose: one-cycle enable pulse every DIV reference cycles
// Assumes: run low holds the divider cleared
// Notes: stands in for a gated derived clock, no second domain
`timescale 1ns/10ps
module rwc_clk_div #(
  parameter int DIV = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic run,
  output logic en
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt;

  always_ff @(posedge ref_clk) begin
    if (!nrst || !run) begin
      cnt <= '0;
      en <= 1'b0;
    end else begin
      en <= (cnt == CW'(DIV - 1));
      if (cnt == CW'(DIV - 1)) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + CW'(1);
      end
    end
  end
endmodule

// file: src/rwc_pkg.sv
// Purpose: shared constants and types for the reset and watchdog control block
// Assumes: ref_clk at 40 MHz; all registers are 8 bits wide on a plain port
// Notes: all timing is derived from the reference period below
package rwc_pkg;
  localparam int REF_CLK_HZ = 40_000_000;
  localparam int REF_CLK_PS = 25_000;
  localparam int INSTR_CLK_HZ = 10_000_000;
  localparam int PERIPH_CLK_HZ = 20_000_000;
  localparam int INSTR_DIV = REF_CLK_HZ / INSTR_CLK_HZ;
  localparam int PERIPH_DIV = REF_CLK_HZ / PERIPH_CLK_HZ;
  localparam longint OSC_STARTUP_NS = 1_000_000;
  localparam int OSC_STARTUP_CYC = int'((OSC_STARTUP_NS * 1000 + REF_CLK_PS - 1) / REF_CLK_PS);
  localparam int RST_PULSE_NS = 400;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * 1000) / REF_CLK_PS;
  localparam int WD_MIN_LOG2 = 12;
  localparam int WD_LOG2_STEP = 3;
  localparam int WD_PRE_PERIODS = 512;
  localparam logic [15:0] RESET_VECTOR = 16'h8000;
  localparam logic [7:0] HOST_RESET_CMD = 8'hbb;
  localparam logic [3:0] REG_WDCTL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int WD_POR_BIT = 7;
  localparam int WD_IE_BIT = 6;
  localparam int WD_SEL_LSB = 4;
  localparam int WD_RE_BIT = 3;
  localparam int WD_IF_BIT = 2;
  localparam int WD_RF_BIT = 1;
  localparam int WD_RESTART_BIT = 0;
  localparam int ST_OSC_BIT = 0;
  localparam int ST_STARTUP_BIT = 1;
  localparam int ST_EXT_BIT = 4;
  localparam int ST_HOST_BIT = 5;
  localparam int ST_LDR_BIT = 6;
  localparam int ST_SW_BIT = 7;
  localparam logic [1:0] WD_SEL_RST = 2'h0;
  localparam logic [1:0] SYNC_RST = 2'h2;
  typedef enum logic [2:0] {
    SEQ_BROWNOUT = 3'h1,
    SEQ_STARTUP = 3'h2,
    SEQ_CPU = 3'h4
  } rwc_seq_e;
endpackage

// file: src/rwc_sync.sv
// Purpose: two-stage synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels; one clock domain
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module rwc_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// file: src/rwc_top.sv
// Purpose: brownout sequencing, reset merging and watchdog for the core
// Assumes: supply_ok and rst_pin_n are asynchronous; other requests are on ref_clk
// Notes: por_rst_n is the only reset that DAC and PWM logic may use
`timescale 1ns/10ps
module rwc_top #(
  parameter int STARTUP_CYC = rwc_pkg::OSC_STARTUP_CYC,
  parameter int WD_MIN_LOG2 = rwc_pkg::WD_MIN_LOG2
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic supply_ok,
  input wire logic rst_pin_n,
  input wire logic host_cmd_valid,
  input wire logic [7:0] host_cmd_byte,
  input wire logic isp_done,
  input wire logic loader_done_bit,
  input wire logic boot_sw_reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic osc_out_en,
  output logic instruction_clock_en,
  output logic periph_clk_en,
  output logic sys_rst_n,
  output logic por_rst_n,
  output logic [15:0] reset_vector,
  output logic wd_irq,
  output logic cpu_state
);
  localparam int WD_CW = WD_MIN_LOG2 + 3 * rwc_pkg::WD_LOG2_STEP + 1;
  localparam int SU_W = $clog2(STARTUP_CYC + 1);
  localparam int RC_W = $clog2(rwc_pkg::RST_PULSE_CYC + 1);
  localparam int PC_W = $clog2(rwc_pkg::WD_PRE_PERIODS);

  logic [1:0] sync_q;
  logic sup_ok_s;
  logic pin_n_s;
  rwc_pkg::rwc_seq_e seq;
  logic [SU_W-1:0] su_cnt;
  logic [RC_W-1:0] rst_cnt;
  logic blk_rst;
  logic sys_rst_act;
  logic host_evt;
  logic ldr_evt;
  logic sw_evt;
  logic int_evt;
  logic wr_wd;
  logic wr_st;
  logic restart;
  logic wd_ie;
  logic wd_re;
  logic [1:0] wd_sel;
  logic por_flag;
  logic wd_if;
  logic wd_rf;
  logic ext_flag;
  logic host_flag;
  logic ldr_flag;
  logic sw_flag;
  logic [WD_CW-1:0] wd_cnt;
  logic [WD_CW-1:0] wd_lim;
  logic pre_act;
  logic [PC_W-1:0] pre_cnt;
  logic wd_ok;
  logic wd_expire;
  logic wd_end;
  logic wd_fire;

  // Supply comparator and reset pin come from outside the clock
  rwc_sync #(
    .W(2),
    .RST_VAL(rwc_pkg::SYNC_RST)
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din({rst_pin_n, supply_ok}),
    .dout(sync_q)
  );
  assign pin_n_s = sync_q[1];
  assign sup_ok_s = sync_q[0];

  // Brownout sequencer
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      seq <= rwc_pkg::SEQ_BROWNOUT;
    end else begin
      unique case (seq)
        rwc_pkg::SEQ_BROWNOUT: begin
          if (sup_ok_s) begin
            seq <= rwc_pkg::SEQ_STARTUP;
          end
        end
        rwc_pkg::SEQ_STARTUP: begin
          if (!sup_ok_s) begin
            seq <= rwc_pkg::SEQ_BROWNOUT;
          end else if (su_cnt == SU_W'(STARTUP_CYC - 1)) begin
            seq <= rwc_pkg::SEQ_CPU;
          end
        end
        rwc_pkg::SEQ_CPU: begin
          // Detector stays armed while running
          if (!sup_ok_s) begin
            seq <= rwc_pkg::SEQ_BROWNOUT;
          end
        end
        default: seq <= rwc_pkg::SEQ_BROWNOUT;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst || seq != rwc_pkg::SEQ_STARTUP) begin
      su_cnt <= '0;
    end else begin
      su_cnt <= su_cnt + SU_W'(1);
    end
  end

  assign cpu_state = (seq == rwc_pkg::SEQ_CPU);
  // Oscillator output is internal only; it is released in CPU state
  assign osc_out_en = cpu_state;

  rwc_clk_div #(
    .DIV(rwc_pkg::INSTR_DIV)
  ) u_instr_div (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(osc_out_en),
    .en(instruction_clock_en)
  );

  rwc_clk_div #(
    .DIV(rwc_pkg::PERIPH_DIV)
  ) u_periph_div (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(osc_out_en),
    .en(periph_clk_en)
  );

  // Brownout is handled as a power-on reset
  assign blk_rst = !nrst || !cpu_state;
  assign sys_rst_act = !sys_rst_n;

  // Internal reset requests are only honoured while the core runs
  assign host_evt = cpu_state && sys_rst_n && host_cmd_valid &&
                    (host_cmd_byte == rwc_pkg::HOST_RESET_CMD);
  assign ldr_evt = cpu_state && sys_rst_n && isp_done && loader_done_bit;
  assign sw_evt = cpu_state && sys_rst_n && boot_sw_reset;
  assign int_evt = host_evt || ldr_evt || sw_evt || wd_fire;

  // All internal sources share one stretcher so their effect is identical
  always_ff @(posedge ref_clk) begin
    if (blk_rst) begin
      rst_cnt <= '0;
    end else if (int_evt) begin
      rst_cnt <= RC_W'(rwc_pkg::RST_PULSE_CYC - 1);
    end else if (rst_cnt != '0) begin
      rst_cnt <= rst_cnt - RC_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sys_rst_n <= 1'b0;
    end else begin
      sys_rst_n <= cpu_state && pin_n_s && (rst_cnt == '0) && !int_evt;
    end
  end

  // DAC and PWM see only the power-on class of reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      por_rst_n <= 1'b0;
    end else begin
      por_rst_n <= cpu_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reset_vector <= rwc_pkg::RESET_VECTOR;
    end else begin
      reset_vector <= rwc_pkg::RESET_VECTOR;
    end
  end

  assign wr_wd = reg_wr && (reg_addr == rwc_pkg::REG_WDCTL);
  assign wr_st = reg_wr && (reg_addr == rwc_pkg::REG_STATUS);
  assign restart = wr_wd && reg_wdata[rwc_pkg::WD_RESTART_BIT];

  // Watchdog settings return to their defaults on every reset kind
  always_ff @(posedge ref_clk) begin
    if (blk_rst || sys_rst_act) begin
      wd_ie <= 1'b0;
      wd_re <= 1'b0;
      wd_sel <= rwc_pkg::WD_SEL_RST;
    end else if (wr_wd) begin
      wd_ie <= reg_wdata[rwc_pkg::WD_IE_BIT];
      wd_re <= reg_wdata[rwc_pkg::WD_RE_BIT];
      wd_sel <= reg_wdata[rwc_pkg::WD_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (blk_rst) begin
      por_flag <= 1'b1;
    end else if (wr_wd && reg_wdata[rwc_pkg::WD_POR_BIT]) begin
      por_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (blk_rst) begin
      wd_rf <= 1'b0;
    end else if (wd_fire) begin
      wd_rf <= 1'b1;
    end else if (wr_wd && reg_wdata[rwc_pkg::WD_RF_BIT]) begin
      wd_rf <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (blk_rst || sys_rst_act) begin
      wd_if <= 1'b0;
    end else if (wd_expire) begin
      wd_if <= 1'b1;
    end else if (wr_wd && reg_wdata[rwc_pkg::WD_IF_BIT]) begin
      wd_if <= 1'b0;
    end
  end

  assign wd_irq = wd_if && wd_ie;

  // Cause flags survive every reset except the power-on class
  always_ff @(posedge ref_clk) begin
    if (blk_rst) begin
      ext_flag <= 1'b0;
      host_flag <= 1'b0;
      ldr_flag <= 1'b0;
      sw_flag <= 1'b0;
    end else begin
      ext_flag <= !pin_n_s || (ext_flag && !(wr_st && reg_wdata[rwc_pkg::ST_EXT_BIT]));
      host_flag <= host_evt || (host_flag && !(wr_st && reg_wdata[rwc_pkg::ST_HOST_BIT]));
      ldr_flag <= ldr_evt || (ldr_flag && !(wr_st && reg_wdata[rwc_pkg::ST_LDR_BIT]));
      sw_flag <= sw_evt || (sw_flag && !(wr_st && reg_wdata[rwc_pkg::ST_SW_BIT]));
    end
  end

  always_comb begin
    wd_lim = (WD_CW'(1) << (WD_MIN_LOG2 + rwc_pkg::WD_LOG2_STEP * int'(wd_sel)))
             - WD_CW'(1);
  end

  assign wd_ok = !blk_rst && !sys_rst_act && !restart;
  assign wd_expire = wd_ok && instruction_clock_en && !pre_act && (wd_cnt == wd_lim);
  assign wd_end = wd_ok && instruction_clock_en && pre_act &&
                  (pre_cnt == PC_W'(rwc_pkg::WD_PRE_PERIODS - 1));
  // Reset fires only with the reset enable set; otherwise only the interrupt repeats
  assign wd_fire = wd_end && wd_re;

  // A restart inside the pre-reset window still cancels the reset
  always_ff @(posedge ref_clk) begin
    if (!wd_ok) begin
      wd_cnt <= '0;
      pre_act <= 1'b0;
      pre_cnt <= '0;
    end else if (instruction_clock_en) begin
      if (!pre_act) begin
        if (wd_cnt == wd_lim) begin
          wd_cnt <= '0;
          pre_act <= 1'b1;
        end else begin
          wd_cnt <= wd_cnt + WD_CW'(1);
        end
      end else if (wd_end) begin
        pre_act <= 1'b0;
        pre_cnt <= '0;
      end else begin
        pre_cnt <= pre_cnt + PC_W'(1);
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!nrst || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      unique case (reg_addr)
        rwc_pkg::REG_WDCTL: reg_rdata <= {por_flag, wd_ie, wd_sel, wd_re, wd_if, wd_rf, 1'b0};
        rwc_pkg::REG_STATUS: reg_rdata <= {sw_flag, ldr_flag, host_flag, ext_flag, 2'h0,
                                           seq == rwc_pkg::SEQ_STARTUP, osc_out_en};
        default: reg_rdata <= '0;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_rst_16;
    !sys_rst_n[*8] ##1 !sys_rst_n[*8];
  endsequence

  sequence s_bo_entry;
    !sys_rst_n && !cpu_state;
  endsequence

  // Restart, reset or a control write may legally end the pre-reset window early
  sequence s_pre_quiet;
    (wd_ok && !wr_wd)[*8];
  endsequence

  AST_OSC_RISE: assert property (
    $rose(osc_out_en) |-> $past(seq) == rwc_pkg::SEQ_STARTUP && $past(su_cnt) ==
      SU_W'(STARTUP_CYC - 1))
    else $error("oscillator enabled without full startup delay");

  AST_BO_RESET: assert property (
    (cpu_state && !sup_ok_s) |=> !cpu_state ##1 (s_bo_entry ##0 !por_rst_n))
    else $error("brownout did not assert reset at once");

  AST_STARTUP_ABORT: assert property (
    (seq == rwc_pkg::SEQ_STARTUP && !sup_ok_s) |=> seq == rwc_pkg::SEQ_BROWNOUT)
    else $error("brownout during startup not honoured");

  AST_STARTUP_HOLD: assert property (
    (seq == rwc_pkg::SEQ_STARTUP && sup_ok_s && su_cnt != SU_W'(STARTUP_CYC - 1))
      |=> seq == rwc_pkg::SEQ_STARTUP)
    else $error("left startup early");

  AST_POR_FLAG: assert property (
    (seq == rwc_pkg::SEQ_BROWNOUT) |=> por_flag && !wd_rf && wd_sel == rwc_pkg::WD_SEL_RST)
    else $error("power-on reset did not set flag or clear state");

  AST_DAC_KEEP: assert property (
    (cpu_state && $past(cpu_state) && !sys_rst_n) |-> por_rst_n)
    else $error("dac and pwm reset by non power-on source");

  AST_HOST_RST: assert property (
    host_evt |=> s_rst_16 ##0 host_flag)
    else $error("host reset command pulse wrong");

  AST_WD_PULSE: assert property (
    wd_fire |=> s_rst_16 ##0 wd_rf)
    else $error("watchdog reset pulse not 16 cycles or flag missing");

  AST_WD_PRE: assert property (
    (wd_expire && wd_re) ##1 s_pre_quiet |-> pre_act && wd_if && !wd_fire)
    else $error("watchdog reset too soon after interrupt");

  AST_RESTART: assert property (
    (restart && cpu_state) |=> wd_cnt == '0 && !pre_act)
    else $error("restart did not clear watchdog counter");

  AST_VECTOR: assert property (
    $rose(sys_rst_n) |-> reset_vector == rwc_pkg::RESET_VECTOR)
    else $error("reset vector wrong at release");
endmodule

// file: test/rwc_host_model.sv
// Purpose: far-side model: supply monitor, external reset pin and serial-bus host
// Assumes: the bench calls one task at a time from its main process
// Notes: an idle command byte shows the inverse of the last one, never a stale copy
`timescale 1ns/10ps
module rwc_host_model (
  input wire logic ref_clk,
  output logic supply_ok,
  output logic rst_pin_n,
  output logic host_cmd_valid,
  output logic [7:0] host_cmd_byte
);
  // Supply starts low so the block must wait for it after reset
  initial begin
    supply_ok = 1'b0;
    rst_pin_n = 1'b1;
    host_cmd_valid = 1'b0;
    host_cmd_byte = 8'h00;
  end

  task automatic set_supply(input logic v);
    @(posedge ref_clk);
    supply_ok <= v;
  endtask

  task automatic set_pin(input logic v);
    @(posedge ref_clk);
    rst_pin_n <= v;
  endtask

  task automatic send_cmd(input logic [7:0] b);
    @(posedge ref_clk);
    host_cmd_valid <= 1'b1;
    host_cmd_byte <= b;
    @(posedge ref_clk);
    host_cmd_valid <= 1'b0;
    host_cmd_byte <= ~b;
  endtask
endmodule

// file: test/tb.sv
// Purpose: self-checking bench for the reset and watchdog control block
// Assumes: shortened startup (20 cycles) and watchdog base exponent 4
// Notes: counts are checked with a small window where the divider phase is free
`timescale 1ns/10ps
module tb;
  localparam int STARTUP = 20;
  localparam int MINLOG = 4;
  localparam logic [3:0] A_WD = rwc_pkg::REG_WDCTL;
  localparam logic [3:0] A_ST = rwc_pkg::REG_STATUS;
  logic ref_clk, nrst, isp_done, loader_done_bit, boot_sw_reset, reg_wr, reg_rd;
  logic supply_ok, rst_pin_n, host_cmd_valid;
  logic [7:0] host_cmd_byte, reg_wdata, reg_rdata;
  logic [3:0] reg_addr;
  logic osc_out_en, instruction_clock_en, periph_clk_en, sys_rst_n, por_rst_n, wd_irq;
  logic cpu_state;
  logic [15:0] reset_vector;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  rwc_top #(.STARTUP_CYC(STARTUP), .WD_MIN_LOG2(MINLOG)) uut (
    .ref_clk(ref_clk), .nrst(nrst), .supply_ok(supply_ok), .rst_pin_n(rst_pin_n),
    .host_cmd_valid(host_cmd_valid), .host_cmd_byte(host_cmd_byte), .isp_done(isp_done),
    .loader_done_bit(loader_done_bit), .boot_sw_reset(boot_sw_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .osc_out_en(osc_out_en),
    .instruction_clock_en(instruction_clock_en), .periph_clk_en(periph_clk_en),
    .sys_rst_n(sys_rst_n), .por_rst_n(por_rst_n), .reset_vector(reset_vector),
    .wd_irq(wd_irq), .cpu_state(cpu_state));

  rwc_host_model peer (.ref_clk(ref_clk), .supply_ok(supply_ok), .rst_pin_n(rst_pin_n),
    .host_cmd_valid(host_cmd_valid), .host_cmd_byte(host_cmd_byte));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Longest path is the slowest watchdog interval, about 35k cycles of some 50k in all
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      $display("[ERR] run time expected below 80000 seen %0d", cyc);
      results();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return sys_rst_n;
      1: return cpu_state;
      default: return wd_irq;
    endcase
  endfunction

  task automatic wait_for(input int s, input logic lvl, input int max, output int n);
    n = 0;
    while (sig(s) !== lvl && n < max) begin
      cycles(1);
      n++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, {8'h00, e}, {8'h00, reg_rdata & m});
  endtask

  task automatic t_power();
    int n, ni, np;
    cycles(30);
    chk("osc gated", 1'b0, osc_out_en);
    chk("held in reset", 1'b0, sys_rst_n);
    peer.set_supply(1'b1);
    wait_for(1, 1'b1, 60, n);
    chk_rng("startup wait", STARTUP, STARTUP + 6, n);
    chk("osc on", 1'b1, osc_out_en);
    cycles(2);
    chk("por release", 1'b1, por_rst_n);
    chk("vector", 16'h8000, reset_vector);
    rchk("power flag", A_WD, 8'hff, 8'h80);
    wr(4'h9, 8'hff);
    rchk("unmapped", 4'h9, 8'hff, 8'h00);
    ni = 0;
    np = 0;
    repeat (40) begin
      cycles(1);
      ni += int'(instruction_clock_en);
      np += int'(periph_clk_en);
    end
    chk_rng("instr enables", 10, 10, ni);
    chk_rng("periph enables", 20, 20, np);
  endtask

  task automatic t_pin();
    int n;
    peer.set_pin(1'b0);
    wait_for(0, 1'b0, 10, n);
    chk_rng("pin assert", 1, 5, n);
    cycles(10);
    chk("pin hold", 1'b0, sys_rst_n);
    chk("por kept", 1'b1, por_rst_n);
    peer.set_pin(1'b1);
    wait_for(0, 1'b1, 10, n);
    chk("pin release", 1'b1, sys_rst_n);
    rchk("pin cause", A_ST, 8'hff, 8'h11);
    wr(A_ST, 8'h10);
    rchk("pin cause clear", A_ST, 8'hff, 8'h01);
    rchk("power flag kept", A_WD, 8'hff, 8'h80);
    wr(A_WD, 8'h80);
    rchk("power flag clear", A_WD, 8'hff, 8'h00);
  endtask

  task automatic t_restart();
    int n;
    wr(A_WD, 8'h49);
    cycles(40);
    wr(A_WD, 8'h49);
    wait_for(2, 1'b1, 200, n);
    chk_rng("restart clears count", 56, 72, n);
    // The reset pending from the last interrupt would land near 2046 cycles
    wr(A_WD, 8'h4d);
    wait_for(0, 1'b0, 2080, n);
    chk_rng("restart cancels reset", 2080, 2080, n);
    wr(A_WD, 8'h05);
  endtask

  task automatic t_wdog(input logic [1:0] sel);
    int n, tmo;
    tmo = 4 << (MINLOG + 3 * sel);
    wr(A_WD, {2'b01, sel, 4'b1001});
    wait_for(2, 1'b1, tmo + 20, n);
    chk_rng("irq time", tmo - 8, tmo + 8, n);
    wait_for(0, 1'b0, 2100, n);
    chk_rng("reset after irq", 2040, 2056, n);
    wait_for(0, 1'b1, 40, n);
    chk_rng("reset pulse", 16, 16, n);
    chk("por kept", 1'b1, por_rst_n);
    rchk("wd flag", A_WD, 8'hfb, 8'h02);
    wr(A_WD, 8'h06);
    rchk("wd flag clear", A_WD, 8'hff, 8'h00);
  endtask

  task automatic t_int(input int k, input logic hit, input logic [7:0] st);
    int n;
    @(posedge ref_clk);
    case (k)
      0: peer.send_cmd(8'hbb);
      1, 4: begin
        isp_done <= 1'b1;
        loader_done_bit <= (k == 1);
        @(posedge ref_clk);
        isp_done <= 1'b0;
      end
      2: begin
        boot_sw_reset <= 1'b1;
        @(posedge ref_clk);
        boot_sw_reset <= 1'b0;
      end
      default: peer.send_cmd(8'h5a);
    endcase
    cycles(0);
    wait_for(0, 1'b0, 4, n);
    chk_rng("reset taken", hit ? 0 : 4, hit ? 1 : 4, n);
    wait_for(0, 1'b1, 40, n);
    chk_rng("reset length", hit ? 16 : 0, hit ? 16 : 0, n);
    chk("por kept", 1'b1, por_rst_n);
    rchk("cause", A_ST, 8'hff, st);
  endtask

  task automatic t_brown();
    int n;
    peer.set_supply(1'b0);
    wait_for(0, 1'b0, 10, n);
    chk_rng("brownout assert", 1, 6, n);
    cycles(30);
    chk("brownout hold", 1'b0, sys_rst_n);
    chk("brownout por", 1'b0, por_rst_n);
    peer.set_supply(1'b1);
    cycles(STARTUP / 2);
    peer.set_supply(1'b0);
    wait_for(1, 1'b1, STARTUP + 10, n);
    chk_rng("dip in startup", STARTUP + 10, STARTUP + 10, n);
    peer.set_supply(1'b1);
    wait_for(1, 1'b1, 60, n);
    chk_rng("recovery wait", STARTUP, STARTUP + 6, n);
    cycles(2);
    rchk("brownout flag", A_WD, 8'hff, 8'h80);
    rchk("causes cleared", A_ST, 8'hff, 8'h01);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    isp_done = 1'b0;
    loader_done_bit = 1'b0;
    boot_sw_reset = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    t_power();
    $display("test power done");
    t_pin();
    $display("test pin done");
    t_restart();
    $display("test restart done");
    for (int s = 0; s < 4; s++) begin
      t_wdog(s[1:0]);
    end
    $display("test watchdog done");
    t_int(0, 1'b1, 8'h21);
    t_int(1, 1'b1, 8'h61);
    t_int(2, 1'b1, 8'he1);
    t_int(3, 1'b0, 8'he1);
    t_int(4, 1'b0, 8'he1);
    $display("test internal done");
    t_brown();
    $display("test brownout done");
    results();
  end
endmodule
